// >>> design/brake_seq_pkg.sv
// constants, register map and state type of the brake release sequencer
package brake_seq_pkg;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int WAIT_STEP_US = 10000;
  localparam int WAIT_TICK_CYCLES = WAIT_STEP_US * 1000 / CLK_PERIOD_NS;

  // ***************************************************
  // register byte offsets
  // ***************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMES_A = 8'h04;
  localparam logic [7:0] OFS_TIMES_B = 8'h08;
  localparam logic [7:0] OFS_FREQ = 8'h0C;
  localparam logic [7:0] OFS_CMD_FREQ = 8'h10;
  localparam logic [7:0] OFS_REL_CUR = 8'h14;
  localparam logic [7:0] OFS_IN_FUNC_LO = 8'h18;
  localparam logic [7:0] OFS_IN_FUNC_HI = 8'h1C;
  localparam logic [7:0] OFS_OUT_FUNC_LO = 8'h20;
  localparam logic [7:0] OFS_OUT_FUNC_HI = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  // ***************************************************
  // fields, limits, codes
  // ***************************************************
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int HI_FIELD_LSB = 16;
  localparam logic [1:0] BRAKE_EN_OFF = 2'h0;
  localparam logic [1:0] BRAKE_EN_ON = 2'h1;
  localparam logic [8:0] WAIT_TIME_MAX = 9'h1F4;
  localparam logic [15:0] FREQ_MAX = 16'h9C40;
  localparam logic [11:0] CUR_MAX = 12'h7D0;
  localparam logic [11:0] CUR_MAX_LARGE = 12'h708;
  localparam logic [7:0] IN_FUNC_CONFIRM = 8'h2C;
  localparam logic [7:0] OUT_FUNC_RELEASE = 8'h13;
  localparam logic [7:0] OUT_FUNC_ERROR = 8'h14;
  localparam logic [7:0] BRAKE_ERROR_TRIP_CODE = 8'h24;
  localparam logic [7:0] TRIP_CODE_NONE = 8'h00;
  localparam logic [7:0] FUNC_RESET = 8'hFF;

  typedef enum logic [3:0] {
    ST_IDLE, ST_BYPASS, ST_TO_REL, ST_REL_WAIT, ST_CONF_ON, ST_ACC_WAIT,
    ST_RUN, ST_TO_APPLY, ST_CONF_OFF, ST_STOP_WAIT, ST_TO_ZERO, ST_TRIP
  } brake_state_t;

endpackage

// >>> design/brake_wait_timer.sv
// wait timer counting 10 ms steps up to a loaded limit
module brake_wait_timer
  import brake_seq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic step,
  input wire logic [8:0] limit,
  // result
  output logic done
);

  logic [8:0] count_reg;
  logic [8:0] limit_reg;
  logic running_reg;

  // restart on start, count one per step until the limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= 9'h000;
      limit_reg <= 9'h000;
      running_reg <= 1'b0;
    end
    else if (start)
    begin
      count_reg <= 9'h000;
      limit_reg <= limit;
      running_reg <= 1'b1;
    end
    else if (running_reg && step && count_reg < limit_reg)
    begin
      count_reg <= count_reg + 9'h001;
    end
  end

  // a pending start hides the expiry of the previous wait
  assign done = running_reg && !start && (count_reg == limit_reg);

endmodule

// >>> design/brake_release_sequencer.sv
// brake release sequencer with apb registers and terminal routing
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
module brake_release_sequencer
  import brake_seq_pkg::*;
#(
  parameter int TICK_CYCLES = WAIT_TICK_CYCLES,
  parameter int IN_TERMS = 8,
  parameter int OUT_TERMS = 5,
  parameter bit LARGE_RATING = 1'b0
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive feedback, 0.01 Hz and 0.1 % of rated current
  input wire logic [15:0] out_freq,
  input wire logic [11:0] out_current,
  // drive commands
  output logic drive_run,
  output logic ramp_hold,
  output logic [15:0] freq_target,
  // terminals
  input wire logic [IN_TERMS-1:0] in_terminals,
  output logic [OUT_TERMS-1:0] out_terminals,
  output logic brake_release_out,
  output logic brake_error_out
);

  // ***************************************************
  // declarations
  // ***************************************************
  brake_state_t state_reg;
  logic [1:0] brake_ctrl_enable_reg;
  logic run_reg;
  logic clear_reg;
  logic [8:0] release_wait_time_reg;
  logic [8:0] accel_wait_time_reg;
  logic [8:0] stop_wait_time_reg;
  logic [8:0] confirm_wait_time_reg;
  logic [15:0] release_frequency_reg;
  logic [15:0] brake_apply_frequency_reg;
  logic [15:0] cmd_freq_reg;
  logic [11:0] release_current_reg;
  logic [7:0] in_func_reg [IN_TERMS];
  logic [7:0] out_func_reg [OUT_TERMS];
  logic [IN_TERMS-1:0] in_meta_reg;
  logic [IN_TERMS-1:0] in_sync_reg;
  logic [31:0] presc_reg;
  logic step_reg;
  logic tmr_start_reg;
  logic [8:0] tmr_limit_reg;
  logic tmr_done;
  logic brake_release_reg;
  logic brake_error_reg;
  logic [7:0] trip_code_reg;
  logic [31:0] rdata_next;
  logic [IN_TERMS-1:0] confirm_mask;
  logic confirm_assigned;
  logic confirm;
  logic fail_next;
  logic setup;
  logic wr;

  // clamp a wait time to its top value
  function automatic logic [8:0] clamp_time(input logic [31:0] v);
    clamp_time = (v[15:0] > 16'(WAIT_TIME_MAX)) ? WAIT_TIME_MAX : v[8:0];
  endfunction

  // clamp a frequency to its top value
  function automatic logic [15:0] clamp_freq(input logic [15:0] v);
    clamp_freq = (v > FREQ_MAX) ? FREQ_MAX : v;
  endfunction

  // ***************************************************
  // apb slave
  // ***************************************************
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite && !pslverr;

  // read data and decode error prepared in the setup cycle
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rdata_next = {29'h0, run_reg, brake_ctrl_enable_reg};
      OFS_TIMES_A: rdata_next = {7'h0, accel_wait_time_reg, 7'h0, release_wait_time_reg};
      OFS_TIMES_B: rdata_next = {7'h0, confirm_wait_time_reg, 7'h0, stop_wait_time_reg};
      OFS_FREQ: rdata_next = {brake_apply_frequency_reg, release_frequency_reg};
      OFS_CMD_FREQ: rdata_next = {16'h0, cmd_freq_reg};
      OFS_REL_CUR: rdata_next = {20'h0, release_current_reg};
      OFS_IN_FUNC_LO: rdata_next = {in_func_reg[3], in_func_reg[2], in_func_reg[1], in_func_reg[0]};
      OFS_IN_FUNC_HI: rdata_next = {in_func_reg[7], in_func_reg[6], in_func_reg[5], in_func_reg[4]};
      OFS_OUT_FUNC_LO: rdata_next = {out_func_reg[3], out_func_reg[2], out_func_reg[1], out_func_reg[0]};
      OFS_OUT_FUNC_HI: rdata_next = {24'h0, out_func_reg[4]};
      OFS_STATUS: rdata_next = {16'h0, trip_code_reg, 1'b0, confirm_assigned, brake_error_reg,
                                brake_release_reg, state_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // zero wait states: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && (paddr > OFS_STATUS || paddr[1:0] != 2'h0);
      if (setup)
      begin
        prdata <= rdata_next;
      end
    end
  end

  // register writes; wait times, frequencies and release current are clamped into their legal span
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brake_ctrl_enable_reg <= BRAKE_EN_OFF;
      run_reg <= 1'b0;
      clear_reg <= 1'b0;
      release_wait_time_reg <= 9'h000;
      accel_wait_time_reg <= 9'h000;
      stop_wait_time_reg <= 9'h000;
      confirm_wait_time_reg <= 9'h000;
      release_frequency_reg <= 16'h0000;
      brake_apply_frequency_reg <= 16'h0000;
      cmd_freq_reg <= 16'h0000;
      release_current_reg <= 12'h000;
      for (int i = 0; i < IN_TERMS; i++)
      begin
        in_func_reg[i] <= FUNC_RESET;
      end
      for (int i = 0; i < OUT_TERMS; i++)
      begin
        out_func_reg[i] <= FUNC_RESET;
      end
    end
    else
    begin
      clear_reg <= wr && paddr == OFS_CTRL && pwdata[CTRL_CLEAR_BIT];
      if (wr)
      begin
        case (paddr)
          OFS_CTRL:
          begin
            brake_ctrl_enable_reg <= pwdata[1:0];
            run_reg <= pwdata[CTRL_RUN_BIT];
          end
          OFS_TIMES_A:
          begin
            release_wait_time_reg <= clamp_time({16'h0, pwdata[15:0]});
            accel_wait_time_reg <= clamp_time({16'h0, pwdata[31:HI_FIELD_LSB]});
          end
          OFS_TIMES_B:
          begin
            stop_wait_time_reg <= clamp_time({16'h0, pwdata[15:0]});
            confirm_wait_time_reg <= clamp_time({16'h0, pwdata[31:HI_FIELD_LSB]});
          end
          OFS_FREQ:
          begin
            release_frequency_reg <= clamp_freq(pwdata[15:0]);
            brake_apply_frequency_reg <= clamp_freq(pwdata[31:HI_FIELD_LSB]);
          end
          OFS_CMD_FREQ: cmd_freq_reg <= clamp_freq(pwdata[15:0]);
          OFS_REL_CUR:
          begin
            if (pwdata[15:0] > 16'(LARGE_RATING ? CUR_MAX_LARGE : CUR_MAX))
            begin
              release_current_reg <= LARGE_RATING ? CUR_MAX_LARGE : CUR_MAX;
            end
            else
            begin
              release_current_reg <= pwdata[11:0];
            end
          end
          OFS_IN_FUNC_LO:
          begin
            for (int i = 0; i < 4; i++)
            begin
              in_func_reg[i] <= pwdata[8*i +: 8];
            end
          end
          OFS_IN_FUNC_HI:
          begin
            for (int i = 0; i < 4; i++)
            begin
              in_func_reg[i+4] <= pwdata[8*i +: 8];
            end
          end
          OFS_OUT_FUNC_LO:
          begin
            for (int i = 0; i < 4; i++)
            begin
              out_func_reg[i] <= pwdata[8*i +: 8];
            end
          end
          OFS_OUT_FUNC_HI: out_func_reg[4] <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // ***************************************************
  // input terminals and wait timer
  // ***************************************************
  // two-flop synchroniser on the terminal pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_meta_reg <= '0;
      in_sync_reg <= '0;
    end
    else
    begin
      in_meta_reg <= in_terminals;
      in_sync_reg <= in_meta_reg;
    end
  end

  // confirm is any terminal carrying the confirm function
  always_comb
  begin
    for (int i = 0; i < IN_TERMS; i++)
    begin
      confirm_mask[i] = (in_func_reg[i] == IN_FUNC_CONFIRM);
    end
  end
  assign confirm_assigned = |confirm_mask;
  assign confirm = |(confirm_mask & in_sync_reg);

  // 10 ms step prescaler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_reg <= 32'h0000_0000;
      step_reg <= 1'b0;
    end
    else
    begin
      step_reg <= (presc_reg == 32'(TICK_CYCLES - 1));
      presc_reg <= (presc_reg == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : presc_reg + 32'h1;
    end
  end

  brake_wait_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(tmr_start_reg),
    .step(step_reg),
    .limit(tmr_limit_reg),
    .done(tmr_done)
  );

  // ***************************************************
  // sequencer
  // ***************************************************
  // failure conditions of the current state
  always_comb
  begin
    case (state_reg)
      ST_REL_WAIT: fail_next = tmr_done && run_reg && out_current < release_current_reg;
      ST_CONF_ON: fail_next = tmr_done && !confirm;
      ST_ACC_WAIT, ST_RUN, ST_TO_APPLY: fail_next = confirm_assigned && !confirm;
      ST_CONF_OFF: fail_next = tmr_done && confirm;
      default: fail_next = 1'b0;
    endcase
  end

  // state, brake release, brake error and trip code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      brake_release_reg <= 1'b0;
      brake_error_reg <= 1'b0;
      trip_code_reg <= TRIP_CODE_NONE;
      tmr_start_reg <= 1'b0;
      tmr_limit_reg <= 9'h000;
    end
    else
    begin
      tmr_start_reg <= 1'b0;
      if (fail_next)
      begin
        state_reg <= ST_TRIP;
        brake_release_reg <= 1'b0;
        brake_error_reg <= 1'b1;
        trip_code_reg <= BRAKE_ERROR_TRIP_CODE;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (run_reg)
            begin
              state_reg <= (brake_ctrl_enable_reg == BRAKE_EN_ON) ? ST_TO_REL : ST_BYPASS;
            end
          end
          ST_BYPASS:
          begin
            if (!run_reg && out_freq == 16'h0000)
            begin
              state_reg <= ST_IDLE;
            end
          end
          ST_TO_REL:
          begin
            if (!run_reg)
            begin
              state_reg <= ST_TO_ZERO;
            end
            else if (out_freq >= release_frequency_reg)
            begin
              state_reg <= ST_REL_WAIT;
              tmr_start_reg <= 1'b1;
              tmr_limit_reg <= release_wait_time_reg;
            end
          end
          ST_REL_WAIT:
          begin
            if (!run_reg)
            begin
              state_reg <= ST_TO_ZERO;
            end
            else if (tmr_done)
            begin
              brake_release_reg <= 1'b1;
              tmr_start_reg <= 1'b1;
              state_reg <= confirm_assigned ? ST_CONF_ON : ST_ACC_WAIT;
              tmr_limit_reg <= confirm_assigned ? confirm_wait_time_reg : accel_wait_time_reg;
            end
          end
          ST_CONF_ON:
          begin
            if (confirm)
            begin
              state_reg <= ST_ACC_WAIT;
              tmr_start_reg <= 1'b1;
              tmr_limit_reg <= accel_wait_time_reg;
            end
          end
          ST_ACC_WAIT:
          begin
            if (!run_reg)
            begin
              state_reg <= ST_TO_APPLY;
            end
            else if (tmr_done)
            begin
              state_reg <= ST_RUN;
            end
          end
          ST_RUN:
          begin
            if (!run_reg)
            begin
              state_reg <= ST_TO_APPLY;
            end
          end
          ST_TO_APPLY:
          begin
            if (out_freq <= brake_apply_frequency_reg)
            begin
              brake_release_reg <= 1'b0;
              tmr_start_reg <= 1'b1;
              state_reg <= confirm_assigned ? ST_CONF_OFF : ST_STOP_WAIT;
              tmr_limit_reg <= confirm_assigned ? confirm_wait_time_reg : stop_wait_time_reg;
            end
          end
          ST_CONF_OFF:
          begin
            if (!confirm)
            begin
              state_reg <= ST_STOP_WAIT;
              tmr_start_reg <= 1'b1;
              tmr_limit_reg <= stop_wait_time_reg;
            end
          end
          ST_STOP_WAIT:
          begin
            if (tmr_done)
            begin
              state_reg <= ST_TO_ZERO;
            end
          end
          ST_TO_ZERO:
          begin
            if (out_freq == 16'h0000)
            begin
              state_reg <= ST_IDLE;
            end
          end
          ST_TRIP:
          begin
            if (clear_reg)
            begin
              state_reg <= ST_IDLE;
              brake_error_reg <= 1'b0;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ***************************************************
  // drive commands and output terminals
  // ***************************************************
  // frequency target, hold and run follow the state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_target <= 16'h0000;
      ramp_hold <= 1'b0;
      drive_run <= 1'b0;
    end
    else
    begin
      drive_run <= state_reg != ST_IDLE && state_reg != ST_TRIP;
      ramp_hold <= state_reg inside {ST_REL_WAIT, ST_CONF_ON, ST_ACC_WAIT, ST_CONF_OFF, ST_STOP_WAIT};
      case (state_reg)
        ST_BYPASS: freq_target <= run_reg ? cmd_freq_reg : 16'h0000;
        ST_TO_REL, ST_REL_WAIT, ST_CONF_ON, ST_ACC_WAIT: freq_target <= release_frequency_reg;
        ST_RUN: freq_target <= cmd_freq_reg;
        ST_TO_APPLY, ST_CONF_OFF, ST_STOP_WAIT: freq_target <= brake_apply_frequency_reg;
        default: freq_target <= 16'h0000;
      endcase
    end
  end

  // terminal routing by function code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_terminals <= '0;
      brake_release_out <= 1'b0;
      brake_error_out <= 1'b0;
    end
    else
    begin
      brake_release_out <= brake_release_reg;
      brake_error_out <= brake_error_reg;
      for (int i = 0; i < OUT_TERMS; i++)
      begin
        out_terminals[i] <= (out_func_reg[i] == OUT_FUNC_RELEASE && brake_release_reg) ||
                            (out_func_reg[i] == OUT_FUNC_ERROR && brake_error_reg);
      end
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_release_end;
    state_reg == ST_REL_WAIT && tmr_done && run_reg;
  endsequence

  chk_bypass_no_seq: assert property (
    state_reg == ST_IDLE && run_reg && brake_ctrl_enable_reg != BRAKE_EN_ON |=> state_reg == ST_BYPASS)
    else $error("enabled sequence taken without enable");
  chk_release_target: assert property (
    state_reg == ST_TO_REL ##1 state_reg == ST_TO_REL |-> freq_target == $past(release_frequency_reg))
    else $error("target not held at release frequency");
  chk_release_on: assert property (
    s_release_end and out_current >= release_current_reg |=> brake_release_reg ##2 brake_release_out)
    else $error("brake release not asserted after wait");
  chk_low_current: assert property (
    s_release_end and out_current < release_current_reg |=> !brake_release_reg && brake_error_reg)
    else $error("low current did not trip");
  chk_skip_confirm: assert property (
    s_release_end and !confirm_assigned and !fail_next |=> state_reg == ST_ACC_WAIT)
    else $error("confirm wait not skipped");
  chk_confirm_lost: assert property (
    state_reg == ST_RUN && confirm_assigned && !confirm |=> state_reg == ST_TRIP ##1 brake_error_out)
    else $error("lost confirm did not trip");
  chk_trip_state: assert property (
    state_reg == ST_TRIP |-> !brake_release_reg && brake_error_reg && trip_code_reg == BRAKE_ERROR_TRIP_CODE)
    else $error("trip state outputs wrong");
  chk_trip_holds: assert property (
    state_reg == ST_TRIP && !clear_reg |=> state_reg == ST_TRIP)
    else $error("trip left without clear");
  chk_apply_release_off: assert property (
    state_reg == ST_TO_APPLY && !fail_next && out_freq <= brake_apply_frequency_reg |=> !brake_release_reg)
    else $error("release not dropped at apply frequency");

endmodule

// >>> sim/brake_model.sv
// external brake with release confirmation contact
module brake_model #(
  parameter int DLY = 6
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // brake side
  input wire logic release_cmd,
  input wire logic fail,
  output logic confirm
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // contact follows release after a mechanical delay; fail holds it open
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      confirm <= 1'b0;
    end
    else if (fail)
      confirm <= 1'b0;
    else if (confirm != release_cmd)
    begin
      cnt <= cnt + 1;
      if (cnt == DLY)
      begin
        confirm <= release_cmd;
        cnt <= 0;
      end
    end
  end
endmodule

// >>> sim/brake_release_sequencer_tb_top.sv
// apb driven tests of the brake release sequencer
module brake_release_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import brake_seq_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fail = 0, confirm;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, drive_run, ramp_hold, brake_release_out, brake_error_out;
  logic [15:0] out_freq = 16'h0, freq_target;
  logic [11:0] out_current = 12'h0, cur = 12'h320;
  logic [4:0] out_terminals;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  brake_release_sequencer #(.TICK_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_freq(out_freq), .out_current(out_current),
    .drive_run(drive_run), .ramp_hold(ramp_hold), .freq_target(freq_target),
    .in_terminals({7'h00, confirm}), .out_terminals(out_terminals),
    .brake_release_out(brake_release_out), .brake_error_out(brake_error_out));
  brake_model u_brake (.pclk(pclk), .presetn(presetn), .release_cmd(brake_release_out),
    .fail(fail), .confirm(confirm));
  // clock
  initial
  begin
    forever #10 pclk = ~pclk;
  end
  // drive ramp model: moves 1 Hz a cycle unless held
  always @(posedge pclk)
  begin
    out_current <= drive_run ? cur : 12'h000;
    if (!drive_run)
      out_freq <= 16'h0000;
    else if (!ramp_hold && out_freq < freq_target)
      out_freq <= out_freq + 16'h0064;
    else if (!ramp_hold && out_freq > freq_target)
      out_freq <= out_freq - 16'h0064;
  end
  // hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll status until the state field shows s
  task automatic wait_st(input logic [3:0] s);
    int i = 0;
    // always read at least once: rd may still hold a stale control word
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0);
      i++;
    end
    while (i < 400 && rd[3:0] !== s);
    check(rd[3:0], s);
  endtask
  task automatic trip_and_clear();
    wait_st(4'hB);
    check({brake_error_out, brake_release_out, out_terminals[1:0]}, 4'hA);
    check(rd[15:0], 16'h246B);
    apb(1'b1, OFS_CTRL, 32'h0000_0009);
    wait_st(4'h0);
    fail <= 1'b0;
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h2C, 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    // over-range settings are clamped to their top values
    apb(1'b1, OFS_TIMES_A, 32'h01FF_0002);
    apb(1'b0, OFS_TIMES_A, 32'h0);
    check(rd, 32'h01F4_0002);
    apb(1'b1, OFS_REL_CUR, 32'h0000_0FFF);
    apb(1'b0, OFS_REL_CUR, 32'h0);
    check(rd, 32'h0000_07D0);
    // short waits; release and apply above start frequency
    apb(1'b1, OFS_TIMES_A, 32'h0002_0002);
    apb(1'b1, OFS_TIMES_B, 32'h0005_0002);
    apb(1'b1, OFS_FREQ, 32'h01F4_03E8);
    apb(1'b1, OFS_CMD_FREQ, 32'h0000_1388);
    apb(1'b1, OFS_REL_CUR, 32'h0000_01F4);
    apb(1'b1, OFS_IN_FUNC_LO, 32'hFFFF_FF2C);
    apb(1'b1, OFS_OUT_FUNC_LO, 32'hFFFF_1413);
    // full sequence with confirmation
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    wait_st(4'h3);
    check({brake_release_out, ramp_hold}, 2'h1);
    wait_st(4'h5);
    check({rd[6:4], out_terminals[1:0]}, 5'h15);
    wait_st(4'h6);
    check({drive_run, ramp_hold, freq_target}, 18'h2_1388);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    wait_st(4'h9);
    check({brake_release_out, out_freq}, 17'h0_01F4);
    wait_st(4'h0);
    // current below threshold at release wait end
    cur <= 12'h064;
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    trip_and_clear();
    cur <= 12'h320;
    // confirmation never arrives
    fail <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    trip_and_clear();
    // confirmation drops while released
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    wait_st(4'h6);
    fail <= 1'b1;
    trip_and_clear();
    // no confirm terminal: straight to acceleration wait
    apb(1'b1, OFS_IN_FUNC_LO, 32'hFFFF_FFFF);
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    wait_st(4'h5);
    check(rd[6:4], 3'h1);
    wait_st(4'h6);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    wait_st(4'h9);
    wait_st(4'h0);
    // bypass
    apb(1'b1, OFS_CTRL, 32'h0000_0004);
    wait_st(4'h1);
    repeat (100) @(posedge pclk);
    check(brake_release_out, 1'b0);
    check({drive_run, freq_target}, 17'h1_1388);
    test_done();
  end
endmodule
